// file: rcseq_regs.vh
// Purpose: constants for the reader command sequencer
// Assumes: 20 MHz REF_CLK, host sits on plain command/fifo ports
// Notes: no software registers inside this block
`ifndef RCSEQ_REGS_VH
`define RCSEQ_REGS_VH
`define RCSEQ_CMD_IDLE 6'h00
`define RCSEQ_CMD_CFG 6'h07
`define RCSEQ_CMD_AUTH1 6'h0c
`define RCSEQ_CMD_CRC 6'h12
`define RCSEQ_CMD_AUTH2 6'h14
`define RCSEQ_CMD_KEY 6'h19
`define RCSEQ_CMD_INIT 6'h3f
`define RCSEQ_KEY_BYTES 4'hc
`define RCSEQ_AUTH1_BYTES 4'h6
`define RCSEQ_CFG_BYTES 4'h2
`define RCSEQ_RST_CYCLES 4'h4
`define RCSEQ_CRC_PRESET 16'h6363
`define RCSEQ_CRC_POLY 16'h8408
`endif

// file: rcseq_top.v
// Purpose: command sequencer of a contactless reader
// Assumes: fifo and nvm are outside; one clock REF_CLK
// Notes: all outputs come from flip-flops
`timescale 1ns/1ns
`include "rcseq_regs.vh"
module rcseq_top (
  input wire REF_CLK,
  input wire NRST,
  input wire HARD_RESET_POWERDOWN_PIN,
  input wire CMD_WR,
  input wire [5:0] CMD_WDATA,
  input wire RD_REQ,
  input wire [5:0] RD_ADDR,
  input wire FIFO_EMPTY,
  input wire [7:0] FIFO_RDATA,
  input wire NVM_ACK,
  input wire AUTH_DONE,
  output reg FIFO_POP,
  output reg [5:0] CMD_REG,
  output reg IDLE_DONE_FLAG,
  output reg RD_ALLOW,
  output reg INIT_RESET_PHASE,
  output reg NVM_LOAD_REQ,
  output reg [15:0] NVM_ADDR,
  output reg AUTH_ONE_GO,
  output reg AUTH_TWO_GO,
  output reg [95:0] KEY_BUF,
  output reg [47:0] AUTH_ARGS,
  output reg [7:0] CRC_VALUE_LOW,
  output reg [7:0] CRC_VALUE_HIGH
);
////////////////////////////////////////////////////////////////////////
localparam S_IDLE = 6'h01;
localparam S_INIT = 6'h02;
localparam S_ARGS = 6'h04;
localparam S_WORK = 6'h08;
localparam S_CRC = 6'h10;
localparam S_NVM = 6'h20;

function [15:0] crc_byte;
  input [15:0] c;
  input [7:0] d;
  integer i;
  reg [15:0] t;
  begin
    t = c ^ {8'h00, d};
    for (i = 0; i < 8; i = i + 1) begin
      if (t[0])
        t = (t >> 1) ^ `RCSEQ_CRC_POLY;
      else
        t = t >> 1;
    end
    crc_byte = t;
  end
endfunction
////////////////////////////////////////////////////////////////////////
reg rst_a_ff;
reg rst_b_ff;
always @(posedge REF_CLK or negedge NRST) begin
  if (!NRST) begin
    rst_a_ff <= 1'b0;
    rst_b_ff <= 1'b0;
  end else begin
    rst_a_ff <= 1'b1;
    rst_b_ff <= rst_a_ff;
  end
end
wire rst_n = rst_b_ff;

// pin synchroniser, first stage read only by the second
reg pin_a_ff;
reg pin_b_ff;
reg pin_c_ff;
always @(posedge REF_CLK or negedge rst_n) begin
  if (!rst_n) begin
    pin_a_ff <= 1'b1;
    pin_b_ff <= 1'b1;
    pin_c_ff <= 1'b1;
  end else begin
    pin_a_ff <= HARD_RESET_POWERDOWN_PIN;
    pin_b_ff <= pin_a_ff;
    pin_c_ff <= pin_b_ff;
  end
end
wire pin_fall = pin_c_ff & ~pin_b_ff;
////////////////////////////////////////////////////////////////////////
reg [5:0] state_ff;
reg [3:0] cnt_ff;
reg [3:0] need_ff;
reg pop_wait_ff;
reg [15:0] crc_ff;

wire host_cmd = CMD_WR & (state_ff != S_INIT);
wire can_pop = ~FIFO_EMPTY & ~FIFO_POP & ~pop_wait_ff;

// a pin fall outranks a host write in the same cycle
wire seq_free = ~pin_fall & ~host_cmd;
wire new_cmd = host_cmd & ~pin_fall;

// side datapaths only move while no restart is due
wire cmd_is_key = (CMD_REG == `RCSEQ_CMD_KEY);
wire cmd_is_auth1 = (CMD_REG == `RCSEQ_CMD_AUTH1);
wire in_args = (state_ff == S_ARGS);
wire in_crc = (state_ff == S_CRC);

wire arg_take = in_args & pop_wait_ff & seq_free;
wire crc_take = in_crc & pop_wait_ff & seq_free;
wire [15:0] crc_next = crc_byte(crc_ff, FIFO_RDATA);
wire page_ok = (state_ff != S_INIT) | (RD_ADDR[5:3] == 3'h0);

// pop, then a wait cycle: one byte in flight at a time
// cuts fifo rate to one byte per three cycles but keeps the byte count exact
wire arg_pop = in_args & can_pop & (cnt_ff < need_ff);
wire pop_go = seq_free & (arg_pop | (in_crc & can_pop));
////////////////////////////////////////////////////////////////////////
// fifo pop strobe and its data-valid shadow
always @(posedge REF_CLK or negedge rst_n) begin
  if (!rst_n) begin
    FIFO_POP <= 1'b0;
    pop_wait_ff <= 1'b0;
  end else begin
    FIFO_POP <= pop_go;
    // popped data arrives the cycle after the pop
    pop_wait_ff <= FIFO_POP;
  end
end

// read gate, one cycle behind the request
always @(posedge REF_CLK or negedge rst_n) begin
  if (!rst_n) begin
    RD_ALLOW <= 1'b0;
  end else begin
    RD_ALLOW <= RD_REQ & page_ok;
  end
end
////////////////////////////////////////////////////////////////////////
// crc datapath, preset again by every new command
always @(posedge REF_CLK or negedge rst_n) begin
  if (!rst_n) begin
    crc_ff <= `RCSEQ_CRC_PRESET;
    CRC_VALUE_LOW <= 8'h00;
    CRC_VALUE_HIGH <= 8'h00;
  end else if (new_cmd) begin
    crc_ff <= `RCSEQ_CRC_PRESET;
  end else if (crc_take) begin
    crc_ff <= crc_next;
    // result tracks the running value after each byte
    CRC_VALUE_LOW <= crc_next[7:0];
    CRC_VALUE_HIGH <= crc_next[15:8];
  end
end

// argument capture; the first byte ends at the bottom
always @(posedge REF_CLK or negedge rst_n) begin
  if (!rst_n) begin
    KEY_BUF <= 96'h0;
    AUTH_ARGS <= 48'h0;
  end else if (arg_take & cmd_is_key) begin
    KEY_BUF <= {FIFO_RDATA, KEY_BUF[95:8]};
  end else if (arg_take & cmd_is_auth1) begin
    AUTH_ARGS <= {FIFO_RDATA, AUTH_ARGS[47:8]};
  end
end
////////////////////////////////////////////////////////////////////////
// command sequencer proper

always @(posedge REF_CLK or negedge rst_n) begin
  if (!rst_n) begin
    // power-on reset lands here first
    state_ff <= S_INIT;
    cnt_ff <= 4'h0;
    need_ff <= 4'h0;
    CMD_REG <= `RCSEQ_CMD_INIT;
    IDLE_DONE_FLAG <= 1'b0;
    INIT_RESET_PHASE <= 1'b1;
    NVM_LOAD_REQ <= 1'b0;
    NVM_ADDR <= 16'h0000;
    AUTH_ONE_GO <= 1'b0;
    AUTH_TWO_GO <= 1'b0;
  end else begin
    AUTH_ONE_GO <= 1'b0;
    AUTH_TWO_GO <= 1'b0;
    IDLE_DONE_FLAG <= 1'b0;
    if (pin_fall) begin
      state_ff <= S_INIT;
      CMD_REG <= `RCSEQ_CMD_INIT;
      INIT_RESET_PHASE <= 1'b1;
      NVM_LOAD_REQ <= 1'b0;
      cnt_ff <= 4'h0;
    end else if (host_cmd) begin
      // fifo is never flushed here
      cnt_ff <= 4'h0;
      NVM_LOAD_REQ <= 1'b0;
      CMD_REG <= `RCSEQ_CMD_IDLE;
      state_ff <= S_IDLE;
      case (CMD_WDATA)
        `RCSEQ_CMD_KEY: begin
          CMD_REG <= CMD_WDATA;
          need_ff <= `RCSEQ_KEY_BYTES;
          state_ff <= S_ARGS;
        end
        `RCSEQ_CMD_AUTH1: begin
          CMD_REG <= CMD_WDATA;
          need_ff <= `RCSEQ_AUTH1_BYTES;
          state_ff <= S_ARGS;
        end
        `RCSEQ_CMD_CFG: begin
          CMD_REG <= CMD_WDATA;
          need_ff <= `RCSEQ_CFG_BYTES;
          state_ff <= S_ARGS;
        end
        `RCSEQ_CMD_AUTH2: begin
          CMD_REG <= CMD_WDATA;
          AUTH_TWO_GO <= 1'b1;
          state_ff <= S_WORK;
        end
        `RCSEQ_CMD_CRC: begin
          CMD_REG <= CMD_WDATA;
          state_ff <= S_CRC;
        end
        default: begin
          // idle, init code and unknown codes all fall to idle
          CMD_REG <= `RCSEQ_CMD_IDLE;
        end
      endcase
    end else begin
      case (state_ff)
        S_INIT: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (INIT_RESET_PHASE) begin
            if (cnt_ff == `RCSEQ_RST_CYCLES) begin
              INIT_RESET_PHASE <= 1'b0;
              NVM_LOAD_REQ <= 1'b1;
              NVM_ADDR <= 16'h0000;
            end
          end else if (NVM_ACK) begin
            NVM_LOAD_REQ <= 1'b0;
            CMD_REG <= `RCSEQ_CMD_IDLE;
            IDLE_DONE_FLAG <= 1'b1;
            state_ff <= S_IDLE;
          end
        end
        S_ARGS: begin
          if (pop_wait_ff) begin
            cnt_ff <= cnt_ff + 4'h1;
            if (~cmd_is_key & ~cmd_is_auth1)
              NVM_ADDR <= {FIFO_RDATA, NVM_ADDR[15:8]};
            if (cnt_ff + 4'h1 == need_ff) begin
              // work begins only once all bytes are in
              if (cmd_is_key) begin
                CMD_REG <= `RCSEQ_CMD_IDLE;
                IDLE_DONE_FLAG <= 1'b1;
                state_ff <= S_IDLE;
              end else if (cmd_is_auth1) begin
                AUTH_ONE_GO <= 1'b1;
                state_ff <= S_WORK;
              end else begin
                NVM_LOAD_REQ <= 1'b1;
                state_ff <= S_NVM;
              end
            end
          end
        end
        S_WORK: begin
          if (AUTH_DONE) begin
            CMD_REG <= `RCSEQ_CMD_IDLE;
            IDLE_DONE_FLAG <= 1'b1;
            state_ff <= S_IDLE;
          end
        end
        S_NVM: begin
          if (NVM_ACK) begin
            NVM_LOAD_REQ <= 1'b0;
            CMD_REG <= `RCSEQ_CMD_IDLE;
            IDLE_DONE_FLAG <= 1'b1;
            state_ff <= S_IDLE;
          end
        end
        S_CRC: begin
          if (~pop_wait_ff & FIFO_EMPTY & ~FIFO_POP) begin
            // stream ends when the fifo runs dry
            CMD_REG <= `RCSEQ_CMD_IDLE;
            IDLE_DONE_FLAG <= 1'b1;
            state_ff <= S_IDLE;
          end
        end
        S_IDLE: begin
          cnt_ff <= 4'h0;
        end
        default: begin
          state_ff <= S_IDLE;
          CMD_REG <= `RCSEQ_CMD_IDLE;
        end
      endcase
    end
  end
end
endmodule // rcseq_top

// file: rcseq_top_asserts.sv
// Purpose: port checks of the command sequencer
// Assumes: one clock REF_CLK
// Notes: checks pause while NRST is low
`timescale 1ns/1ns
module rcseq_top_asserts (
  input wire REF_CLK,
  input wire NRST,
  input wire CMD_WR,
  input wire [5:0] CMD_WDATA,
  input wire RD_REQ,
  input wire [5:0] RD_ADDR,
  input wire FIFO_POP,
  input wire [5:0] CMD_REG,
  input wire IDLE_DONE_FLAG,
  input wire RD_ALLOW,
  input wire INIT_RESET_PHASE,
  input wire NVM_LOAD_REQ
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  wire ini = CMD_REG == 6'h3f;
  wire idl = CMD_REG == 6'h00;
  wire wr0 = !ini && CMD_WR;
  ////////////////////////////////////////////////////////////////////////////
  a_init_holds: assert property (ini |=> CMD_REG inside {6'h3f, 6'h00})
    else $error("command left init early");
  a_abort_quiet: assert property (wr0 && CMD_WDATA == 6'h00
    |=> idl && !IDLE_DONE_FLAG) else $error("abort set flag");
  a_code_taken: assert property (wr0 && CMD_WDATA inside {6'h07, 6'h0c,
    6'h12, 6'h14, 6'h19} |=> CMD_REG == $past(CMD_WDATA))
    else $error("code not taken");
  a_flag_idle: assert property (IDLE_DONE_FLAG
    |-> idl ##1 !IDLE_DONE_FLAG) else $error("flag outside idle");
  a_idle_quiet: assert property ($past(idl) && idl
    |-> !FIFO_POP && !NVM_LOAD_REQ) else $error("idle not quiet");
  a_pop_gap: assert property (FIFO_POP |=> !FIFO_POP)
    else $error("pops too close");
  a_page_zero: assert property (ini && $past(ini) && $past(RD_REQ)
    && $past(RD_ADDR) > 6'h07 |-> !RD_ALLOW) else $error("read in init");
  a_reset_first: assert property ($fell(INIT_RESET_PHASE)
    |-> ##[0:1] NVM_LOAD_REQ && ini) else $error("load not after reset");
  c_flag: cover property (IDLE_DONE_FLAG);
  c_abort: cover property (wr0 && CMD_WDATA == 6'h00 && !idl);
  c_pop: cover property (FIFO_POP);
endmodule // rcseq_top_asserts
bind rcseq_top rcseq_top_asserts u_chk (.REF_CLK(REF_CLK), .NRST(NRST),
  .CMD_WR(CMD_WR), .CMD_WDATA(CMD_WDATA), .RD_REQ(RD_REQ), .RD_ADDR(RD_ADDR),
  .FIFO_POP(FIFO_POP), .CMD_REG(CMD_REG), .IDLE_DONE_FLAG(IDLE_DONE_FLAG),
  .RD_ALLOW(RD_ALLOW), .INIT_RESET_PHASE(INIT_RESET_PHASE),
  .NVM_LOAD_REQ(NVM_LOAD_REQ));

// file: rcseq_far_model.sv
// Purpose: fifo, nvm and auth engine beside the sequencer
// Assumes: popped byte shows one cycle after the pop
// Notes: stale data toggles so it never passes; lag sets reply speed
`timescale 1ns/1ns
module rcseq_far_model (
  input wire clk,
  input wire pop,
  input wire nvm_req,
  input wire auth_go,
  output logic empty,
  output logic [7:0] rdata,
  output logic nvm_ack,
  output logic auth_done
);
  logic [7:0] q [$];
  int lag = 1;
  int nc = 0;
  int ac = 0;
  initial {empty, rdata, nvm_ack, auth_done} = 11'h400;
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  always @(posedge clk) begin
    nvm_ack <= 1'b0;
    auth_done <= 1'b0;
    rdata <= ~rdata;
    if (pop && q.size() > 0) rdata <= q.pop_front();
    empty <= q.size() == 0;
    nc = (nvm_req && !nvm_ack) ? nc + 1 : 0;
    if (nc >= lag) begin
      nvm_ack <= 1'b1;
      nc = 0;
    end
    if (auth_go) ac = lag;
    else if (ac > 0) begin
      ac = ac - 1;
      auth_done <= ac == 0;
    end
  end
endmodule // rcseq_far_model

// file: reader_command_sequencer_tb_top.sv
// Purpose: self-checking bench of the command sequencer
// Assumes: far side is rcseq_far_model
// Notes: outputs sampled 1 ns after the edge
`timescale 1ns/1ns
`include "rcseq_regs.vh"
module reader_command_sequencer_tb_top;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg pin = 1'b1;
  reg cmd_wr = 1'b0;
  reg rd_req = 1'b0;
  reg [5:0] cmd_wdata = 6'h00;
  reg [5:0] rd_addr = 6'h00;
  wire emp, pop, ack, adone, nreq, a1, a2, flag, rd_ok, rphase;
  wire [7:0] rdat, clo, chi;
  wire [5:0] cmd;
  wire [15:0] naddr;
  wire [95:0] key;
  wire [47:0] args;
  int fails = 0;
  int n_compared = 0;
  logic f;
  logic [95:0] e;
  always #25 clk = ~clk;
  rcseq_top dut (.REF_CLK(clk), .NRST(nrst), .HARD_RESET_POWERDOWN_PIN(pin),
    .CMD_WR(cmd_wr), .CMD_WDATA(cmd_wdata), .RD_REQ(rd_req), .RD_ADDR(rd_addr),
    .FIFO_EMPTY(emp), .FIFO_RDATA(rdat), .NVM_ACK(ack), .AUTH_DONE(adone),
    .FIFO_POP(pop), .CMD_REG(cmd), .IDLE_DONE_FLAG(flag), .RD_ALLOW(rd_ok),
    .INIT_RESET_PHASE(rphase), .NVM_LOAD_REQ(nreq), .NVM_ADDR(naddr),
    .AUTH_ONE_GO(a1), .AUTH_TWO_GO(a2), .KEY_BUF(key), .AUTH_ARGS(args),
    .CRC_VALUE_LOW(clo), .CRC_VALUE_HIGH(chi));
  rcseq_far_model m (.clk(clk), .pop(pop), .nvm_req(nreq),
    .auth_go(a1 | a2), .empty(emp), .rdata(rdat), .nvm_ack(ack),
    .auth_done(adone));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [95:0] ex,
    input logic [95:0] sn);
    n_compared++;
    if (sn !== ex) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic wr(input logic [5:0] c);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_wdata <= c;
    @(posedge clk);
    cmd_wr <= 1'b0;
    #1;
  endtask
  task automatic watch(input int c, inout logic fl);
    repeat (c) begin
      @(posedge clk);
      #1;
      fl = fl | (flag === 1'b1);
    end
  endtask
  task automatic idle_wait(output logic fl);
    int n;
    fl = 1'b0;
    for (n = 0; n < 4000 && cmd !== 6'h00; n++) watch(1, fl);
    watch(2, fl);
    if (n == 4000) begin
      fails++;
      $display("BAD idle wait expected 00 seen %h", cmd);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_power_up_init_cmd();
    @(posedge clk);
    rd_req <= 1'b1;
    rd_addr <= 6'h08;
    wr(`RCSEQ_CMD_KEY);
    chk("init cmd", 6'h3f, cmd);
    chk("page1 read", 0, rd_ok);
    chk("reset phase", 1, rphase);
    idle_wait(f);
    chk("init flag", 1, f);
    chk("reset phase off", 0, rphase);
    chk("page1 after init", 1, rd_ok);
    @(posedge clk);
    rd_req <= 1'b0;
  endtask
  task automatic t_cmds();
    logic [15:0] c;
    logic [7:0] b;
    e = 0;
    for (int i = 0; i < 12; i++) m.push(8'ha0 + i);
    for (int i = 0; i < 12; i++) e[i*8 +: 8] = 8'ha0 + i;
    wr(`RCSEQ_CMD_KEY);
    idle_wait(f);
    chk("key buffer", e, key);
    chk("key flag", 1, f);
    e = 0;
    for (int i = 0; i < 7; i++) m.push(8'h30 + i);
    for (int i = 0; i < 6; i++) e[i*8 +: 8] = 8'h30 + i;
    wr(`RCSEQ_CMD_AUTH1);
    idle_wait(f);
    chk("auth args", e, args);
    chk("auth one flag", 1, f);
    wr(`RCSEQ_CMD_AUTH2);
    idle_wait(f);
    chk("auth two fifo", 1, m.q.size());
    chk("auth two flag", 1, f);
    m.q.delete();
    m.lag = 30;
    m.push(8'h34);
    m.push(8'h12);
    wr(`RCSEQ_CMD_CFG);
    for (int n = 0; n < 50 && nreq !== 1'b1; n++) watch(1, f);
    chk("nvm address", 16'h1234, naddr);
    m.lag = 1;
    idle_wait(f);
    c = `RCSEQ_CRC_PRESET;
    for (int i = 1; i < 4; i++) begin
      b = 8'h5b * i;
      m.push(b);
      c = c ^ b;
      repeat (8) c = c[0] ? (c >> 1) ^ `RCSEQ_CRC_POLY : c >> 1;
    end
    wr(`RCSEQ_CMD_CRC);
    idle_wait(f);
    chk("crc value", c, {chi, clo});
    chk("crc flag", 1, f);
  endtask
  task automatic t_abort();
    int s;
    for (int i = 0; i < 12; i++) m.push(i);
    wr(`RCSEQ_CMD_KEY);
    watch(4, f);
    wr(`RCSEQ_CMD_IDLE);
    f = 1'b0;
    watch(1, f);
    s = m.q.size();
    watch(5, f);
    chk("abort cmd", 0, cmd);
    chk("abort flag", 0, f);
    chk("fifo kept", s, m.q.size());
    wr(`RCSEQ_CMD_INIT);
    watch(1, f);
    chk("host init", 0, cmd);
    m.q.delete();
    @(posedge clk);
    pin <= 1'b0;
    for (int n = 0; n < 10 && cmd !== 6'h3f; n++) watch(1, f);
    chk("pin init", 6'h3f, cmd);
    idle_wait(f);
    chk("pin init flag", 1, f);
  endtask
  initial begin
    m.lag = 20;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_power_up_init_cmd();
    t_cmds();
    t_abort();
    wrap_up();
  end
  initial begin
    #1000000;
    fails++;
    wrap_up();
  end
endmodule // reader_command_sequencer_tb_top
